// File: logic/edge_irq_pkg.sv
// What this block does
// - input interrupts share the counter request line
// - enable register: bit per channel, 1 enables
// - edge register: 0 falling, 1 rising
// - flag register reads 1 after an interrupt
// - writing 1 clears a flag, 0 ignored
// - flag must clear before next service
// - writes control, reads return current status
// - only two input channels can interrupt
package edge_irq_pkg;

   // ==========================================================
   // bus geometry
   localparam int ADDR_WIDTH = 12;
   localparam int DATA_WIDTH = 8;

   // ==========================================================
   // register offsets, byte i/o addresses
   localparam logic [11:0] ENABLE_OFFSET = 12'h202;
   localparam logic [11:0] EDGE_OFFSET = 12'h203;
   localparam logic [11:0] FLAG_OFFSET = 12'h207;
   localparam logic [11:0] OVR_STATUS_OFFSET = 12'h210;
   localparam logic [11:0] OVR_CLEAR_OFFSET = 12'h211;
   localparam logic [11:0] OVR_ENABLE_OFFSET = 12'h212;

   // ==========================================================
   // channel layout, bit 0 is channel a, bit 1 channel b
   localparam int CHANNEL_COUNT = 2;
   localparam int CHAN_A_BIT = 0;
   localparam int CHAN_B_BIT = 1;

   // ==========================================================
   // values after reset
   localparam logic [1:0] ENABLE_RESET = 2'h0;
   localparam logic [1:0] EDGE_RESET = 2'h0;
   localparam logic [1:0] FLAG_RESET = 2'h0;
   localparam logic [1:0] OVR_RESET = 2'h0;
   localparam logic [7:0] READ_RESET = 8'h00;

   // ==========================================================
   // edge select encoding
   localparam logic EDGE_FALLING = 1'h0;
   localparam logic EDGE_RISING = 1'h1;

endpackage

// File: logic/input_edge_sync.sv
`timescale 1ns/1ps
// ==========================================================
// two-flop synchroniser plus edge detector for one field input
module input_edge_sync (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // field side
   input wire logic field_in,
   // edge pulses, one cycle each
   output logic rise_pulse,
   output logic fall_pulse
);
   logic meta; // first stage, read only by sync
   logic sync; // second stage, safe to use
   logic prev; // sync delayed by one cycle
   logic next_meta;
   logic next_sync;
   logic next_prev;

   // next values of the chain
   always_comb begin
      next_meta = field_in;
      next_sync = meta;
      next_prev = sync;
   end

   // chain registers, idle low after reset
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         meta <= 1'h0;
         sync <= 1'h0;
         prev <= 1'h0;
      end else begin
         meta <= next_meta;
         sync <= next_sync;
         prev <= next_prev;
      end
   end

   // edges from the settled stages only
   assign rise_pulse = sync & ~prev;
   assign fall_pulse = ~sync & prev;

endmodule

// File: logic/digital_input_edge_irq.sv
`timescale 1ns/1ps
// ==========================================================
// edge triggered interrupt logic for two isolated inputs
module digital_input_edge_irq (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // register port
   input wire logic [edge_irq_pkg::ADDR_WIDTH-1:0] reg_addr,
   input wire logic [edge_irq_pkg::DATA_WIDTH-1:0] reg_wr_data,
   input wire logic reg_wr_stb,
   input wire logic reg_rd_stb,
   output logic [edge_irq_pkg::DATA_WIDTH-1:0] reg_rd_data,
   // isolated field inputs, asynchronous
   input wire logic isolated_input_a,
   input wire logic isolated_input_b,
   // counter interrupt sharing the line, same clock
   input wire logic counter_irq_req,
   // shared interrupt request, level
   output logic irq_request
);
   import edge_irq_pkg::*;

   // ==========================================================
   // channel edge detection

   logic [CHANNEL_COUNT-1:0] field_pins; // raw pins as a vector
   logic [CHANNEL_COUNT-1:0] rise; // rising edge pulses
   logic [CHANNEL_COUNT-1:0] fall; // falling edge pulses
   logic [CHANNEL_COUNT-1:0] hit; // selected edge seen

   // control and status state
   logic [CHANNEL_COUNT-1:0] input_irq_enable; // per channel enable
   logic [CHANNEL_COUNT-1:0] input_irq_edge_select; // 1 rising
   logic [CHANNEL_COUNT-1:0] input_irq_flag; // sticky flags
   logic [CHANNEL_COUNT-1:0] ovr_status; // edge lost on set flag
   logic [CHANNEL_COUNT-1:0] ovr_enable; // gates ovr onto line

   // next values
   logic [CHANNEL_COUNT-1:0] next_enable;
   logic [CHANNEL_COUNT-1:0] next_edge;
   logic [CHANNEL_COUNT-1:0] next_flag;
   logic [CHANNEL_COUNT-1:0] next_ovr_status;
   logic [CHANNEL_COUNT-1:0] next_ovr_enable;
   logic [DATA_WIDTH-1:0] next_rd_data;
   logic next_irq;

   // decoded write strobes
   logic wr_enable;
   logic wr_edge;
   logic wr_flag;
   logic wr_ovr_clear;
   logic wr_ovr_enable;
   logic [CHANNEL_COUNT-1:0] flag_clear; // write one to clear
   logic [CHANNEL_COUNT-1:0] ovr_clear;
   logic [CHANNEL_COUNT-1:0] set_event; // flag set this cycle
   logic [CHANNEL_COUNT-1:0] lost_event; // edge while pending

   assign field_pins[CHAN_A_BIT] = isolated_input_a;
   assign field_pins[CHAN_B_BIT] = isolated_input_b;

   // two channels only
   // further inputs have no path here; they feed counters elsewhere
   generate
      for (genvar ch = 0; ch < CHANNEL_COUNT; ch++) begin : g_chan
         input_edge_sync u_sync (
            .clk_sys(clk_sys),
            .sys_rst(sys_rst),
            .field_in(field_pins[ch]),
            .rise_pulse(rise[ch]),
            .fall_pulse(fall[ch])
         );
         // edge choice
         // one edge select bit per channel picks the polarity
         assign hit[ch] = (input_irq_edge_select[ch] == EDGE_RISING) ?
            rise[ch] : fall[ch];
      end
   endgenerate

   // ==========================================================
   // write decode

   // a write is a single strobe cycle, no wait states
   always_comb begin
      wr_enable = reg_wr_stb && (reg_addr == ENABLE_OFFSET);
      wr_edge = reg_wr_stb && (reg_addr == EDGE_OFFSET);
      wr_flag = reg_wr_stb && (reg_addr == FLAG_OFFSET);
      wr_ovr_clear = reg_wr_stb && (reg_addr == OVR_CLEAR_OFFSET);
      wr_ovr_enable = reg_wr_stb && (reg_addr == OVR_ENABLE_OFFSET);
      // ones clear
      // zeros in the written byte leave their flag alone
      flag_clear = wr_flag ? reg_wr_data[CHANNEL_COUNT-1:0] : 2'h0;
      ovr_clear = wr_ovr_clear ? reg_wr_data[CHANNEL_COUNT-1:0] : 2'h0;
   end

   // ==========================================================
   // control registers

   // next enable and edge select
   always_comb begin
      next_enable = input_irq_enable;
      next_edge = input_irq_edge_select;
      next_ovr_enable = ovr_enable;
      if (wr_enable) begin
         next_enable = reg_wr_data[CHANNEL_COUNT-1:0];
      end
      if (wr_edge) begin
         next_edge = reg_wr_data[CHANNEL_COUNT-1:0];
      end
      // overrun mask, upper bits dropped
      if (wr_ovr_enable) begin
         next_ovr_enable = reg_wr_data[CHANNEL_COUNT-1:0];
      end
   end

   // control state, enables and overrun mask cleared, edge select falling after reset
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         input_irq_enable <= ENABLE_RESET;
         input_irq_edge_select <= EDGE_RESET;
         ovr_enable <= OVR_RESET;
      end else begin
         input_irq_enable <= next_enable;
         input_irq_edge_select <= next_edge;
         ovr_enable <= next_ovr_enable;
      end
   end

   // ==========================================================
   // flags and overrun status

   // no hazard: changing the edge select only picks the rise or fall pulse
   // and cannot itself make an edge look taken; no need to disable first
   always_comb begin
      set_event = input_irq_enable & hit;
      // pending blocks service
      // an edge on a pending flag is not a new interrupt
      lost_event = set_event & input_irq_flag & ~flag_clear;
      // sticky flag
      // set wins when a clear lands in the same cycle
      next_flag = (input_irq_flag & ~flag_clear) | set_event;
      next_ovr_status = (ovr_status & ~ovr_clear) | lost_event;
   end

   // flag state, clear after reset
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         input_irq_flag <= FLAG_RESET;
         ovr_status <= OVR_RESET;
      end else begin
         input_irq_flag <= next_flag;
         ovr_status <= next_ovr_status;
      end
   end

   // ==========================================================
   // read path and interrupt line

   // reads show status
   // data are registered, so they stand only in the next cycle
   always_comb begin
      next_rd_data = READ_RESET;
      if (reg_rd_stb) begin
         case (reg_addr)
            ENABLE_OFFSET: begin
               next_rd_data[CHANNEL_COUNT-1:0] = input_irq_enable;
            end
            EDGE_OFFSET: begin
               next_rd_data[CHANNEL_COUNT-1:0] = input_irq_edge_select;
            end
            FLAG_OFFSET: begin
               next_rd_data[CHANNEL_COUNT-1:0] = input_irq_flag;
            end
            OVR_STATUS_OFFSET: begin
               next_rd_data[CHANNEL_COUNT-1:0] = ovr_status;
            end
            OVR_ENABLE_OFFSET: begin
               next_rd_data[CHANNEL_COUNT-1:0] = ovr_enable;
            end
            // clear register and unmapped addresses read zero
            default: begin
               next_rd_data = READ_RESET;
            end
         endcase
      end
   end

   // held while pending
   // a disabled channel keeps its flag, which stops driving the line; its overrun bit still drives it if unmasked
   always_comb begin
      next_irq = |(input_irq_flag & input_irq_enable) |
         |(ovr_status & ovr_enable) | counter_irq_req;
   end

   // outputs straight from flops; adds one cycle to the line
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rd_data <= READ_RESET;
         irq_request <= 1'h0;
      end else begin
         reg_rd_data <= next_rd_data;
         irq_request <= next_irq;
      end
   end

   // ==========================================================
   // assertions

   sequence s_armed;
      (set_event != 2'h0);
   endsequence

   sequence s_still_enabled;
      ((input_irq_flag & input_irq_enable) != 2'h0);
   endsequence

   property p_flag_set;
      @(posedge clk_sys) disable iff (sys_rst)
      s_armed |=> ((input_irq_flag & $past(set_event)) == $past(set_event));
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("enabled edge did not set its flag");

   property p_no_set_disabled;
      @(posedge clk_sys) disable iff (sys_rst)
      (input_irq_enable == 2'h0 && input_irq_flag == 2'h0) |=>
         (input_irq_flag == 2'h0);
   endproperty
   a_no_set_disabled: assert property (p_no_set_disabled)
      else $error("flag set while channel disabled");

   property p_irq_follows;
      @(posedge clk_sys) disable iff (sys_rst)
      s_armed ##1 s_still_enabled |=> irq_request;
   endproperty
   a_irq_follows: assert property (p_irq_follows)
      else $error("pending enabled flag did not raise request");

   property p_counter_shared;
      @(posedge clk_sys) disable iff (sys_rst)
      counter_irq_req |=> irq_request;
   endproperty
   a_counter_shared: assert property (p_counter_shared)
      else $error("counter request not on shared line");

   property p_clear_one;
      @(posedge clk_sys) disable iff (sys_rst)
      (wr_flag && reg_wr_data[0] && !set_event[0]) |=> !input_irq_flag[0];
   endproperty
   a_clear_one: assert property (p_clear_one)
      else $error("write one did not clear flag a");

   property p_zero_ignored;
      @(posedge clk_sys) disable iff (sys_rst)
      (input_irq_flag[1] && !flag_clear[1]) |=> input_irq_flag[1];
   endproperty
   a_zero_ignored: assert property (p_zero_ignored)
      else $error("flag b dropped without a clear");

   property p_enable_write;
      @(posedge clk_sys) disable iff (sys_rst)
      wr_enable |=> (input_irq_enable == $past(reg_wr_data[1:0]));
   endproperty
   a_enable_write: assert property (p_enable_write)
      else $error("enable register did not take write");

   property p_edge_write;
      @(posedge clk_sys) disable iff (sys_rst)
      wr_edge |=> (input_irq_edge_select == $past(reg_wr_data[1:0]));
   endproperty
   a_edge_write: assert property (p_edge_write)
      else $error("edge register did not take write");

   property p_flag_read;
      @(posedge clk_sys) disable iff (sys_rst)
      (reg_rd_stb && reg_addr == FLAG_OFFSET) |=>
         (reg_rd_data == {6'h00, $past(input_irq_flag)});
   endproperty
   a_flag_read: assert property (p_flag_read)
      else $error("flag read returned wrong value");

   property p_enable_read;
      @(posedge clk_sys) disable iff (sys_rst)
      (reg_rd_stb && reg_addr == ENABLE_OFFSET) |=>
         (reg_rd_data == {6'h00, $past(input_irq_enable)});
   endproperty
   a_enable_read: assert property (p_enable_read)
      else $error("enable read returned wrong value");

   property p_upper_zero;
      @(posedge clk_sys) disable iff (sys_rst)
      (reg_rd_data[7:2] == 6'h00);
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("bits above two channels read nonzero");

   // an edge that lands on a flag still pending
   sequence s_lost;
      (lost_event != 2'h0);
   endsequence

   property p_overrun_set;
      @(posedge clk_sys) disable iff (sys_rst)
      s_lost |=> ((ovr_status & $past(lost_event)) == $past(lost_event));
   endproperty
   a_overrun_set: assert property (p_overrun_set)
      else $error("edge on pending flag did not set overrun");

   property p_overrun_clear;
      @(posedge clk_sys) disable iff (sys_rst)
      (wr_ovr_clear && reg_wr_data[1] && !lost_event[1]) |=> !ovr_status[1];
   endproperty
   a_overrun_clear: assert property (p_overrun_clear)
      else $error("write one did not clear overrun b");

   property p_clear_b;
      @(posedge clk_sys) disable iff (sys_rst)
      (wr_flag && reg_wr_data[1] && !set_event[1]) |=> !input_irq_flag[1];
   endproperty
   a_clear_b: assert property (p_clear_b)
      else $error("write one did not clear flag b");

   property p_disabled_a;
      @(posedge clk_sys) disable iff (sys_rst)
      (!input_irq_enable[0] && !input_irq_flag[0]) |=> !input_irq_flag[0];
   endproperty
   a_disabled_a: assert property (p_disabled_a)
      else $error("flag a set while channel a disabled");

   property p_line_idle;
      @(posedge clk_sys) disable iff (sys_rst)
      (input_irq_flag == 2'h0 && ovr_status == 2'h0 && !counter_irq_req) |=>
         !irq_request;
   endproperty
   a_line_idle: assert property (p_line_idle)
      else $error("request line high with nothing pending");

   property p_rd_idle;
      @(posedge clk_sys) disable iff (sys_rst)
      !reg_rd_stb |=> (reg_rd_data == 8'h00);
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not zero outside a read");

   property p_edge_read;
      @(posedge clk_sys) disable iff (sys_rst)
      (reg_rd_stb && reg_addr == EDGE_OFFSET) |=>
         (reg_rd_data == {6'h00, $past(input_irq_edge_select)});
   endproperty
   a_edge_read: assert property (p_edge_read)
      else $error("edge select read returned wrong value");

endmodule

// File: tb/field_source.sv
`timescale 1ns/1ps
// ==========================================================
// field side model: two isolated inputs driven off the clock
module field_source (
   // clock
   input wire logic clk_sys,
   // wanted levels, bit 0 channel a, bit 1 channel b
   input wire logic [1:0] level,
   // field pins
   output logic isolated_input_a,
   output logic isolated_input_b
);
   // pins change just after an edge, like a slow contact
   // only two interrupting channels
   always_ff @(posedge clk_sys) begin
      isolated_input_a <= level[0];
      isolated_input_b <= level[1];
   end
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the edge interrupt block
module tb;
   import edge_irq_pkg::*;
   logic clk_sys, sys_rst, reg_wr_stb, reg_rd_stb, counter_irq_req;
   logic [ADDR_WIDTH-1:0] reg_addr;
   logic [DATA_WIDTH-1:0] reg_wr_data, reg_rd_data, got, rv;
   logic [1:0] field_level;
   logic isolated_input_a, isolated_input_b, irq_request;
   int num_errors = 0;
   int compares = 0;

   digital_input_edge_irq uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wr_data(reg_wr_data), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb),
      .reg_rd_data(reg_rd_data), .isolated_input_a(isolated_input_a),
      .isolated_input_b(isolated_input_b), .counter_irq_req(counter_irq_req),
      .irq_request(irq_request));
   field_source field (.clk_sys(clk_sys), .level(field_level),
      .isolated_input_a(isolated_input_a), .isolated_input_b(isolated_input_b));

   // ==========================================================
   // clock, 10 ns period
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // ==========================================================
   // helpers
   // readable image of a two-bit register
   function automatic logic [7:0] img(input logic [7:0] v);
      return {6'h00, v[1:0]};
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic check(input logic [7:0] act, input logic [7:0] exp, input string what);
      compares++;
      if (act !== exp) begin
         num_errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, act, exp);
      end
   endtask
   // one-cycle write strobe
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr_stb <= 1'b1;
      reg_addr <= a;
      reg_wr_data <= d;
      @(posedge clk_sys);
      reg_wr_stb <= 1'b0;
   endtask
   // data stand only in the cycle after the strobe edge
   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_rd_stb <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd_stb <= 1'b0;
      #1 d = reg_rd_data;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [7:0] exp, input string what);
      rd(a, got);
      check(got, exp, what);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // ==========================================================
   // watchdog, far beyond the few hundred cycles needed
   initial begin
      #200000;
      num_errors++;
      print_verdict();
   end

   // ==========================================================
   // main sequence
   initial begin
      sys_rst = 1'b1;
      {reg_wr_stb, reg_rd_stb, counter_irq_req} = 3'h0;
      reg_addr = 12'h000;
      reg_wr_data = 8'h00;
      field_level = 2'h0;
      void'($urandom(32'h641a1265));
      cyc(2);
      sys_rst <= 1'b0;
      // reset values and an unmapped place
      rdchk(ENABLE_OFFSET, 8'h00, "enable reset");
      rdchk(EDGE_OFFSET, 8'h00, "edge reset");
      rdchk(FLAG_OFFSET, 8'h00, "flag reset");
      wr(12'h300, 8'hFF);
      rdchk(12'h300, 8'h00, "unmapped");
      $display("test reset done");
      // random settings read back as status, back to back
      for (int i = 0; i < 8; i++) begin
         rv = 8'($urandom);
         wr(ENABLE_OFFSET, rv);
         rdchk(ENABLE_OFFSET, img(rv), "enable rb");
         wr(EDGE_OFFSET, ~rv);
         rdchk(EDGE_OFFSET, img(~rv), "edge rb");
      end
      $display("test readback done");
      // each channel, each edge; other channel toggles disabled
      for (int ch = 0; ch < 2; ch++) begin
         for (int e = 0; e < 2; e++) begin
            wr(ENABLE_OFFSET, 8'h00);
            field_level <= e[0] ? 2'h3 : 2'h0;
            cyc(6);
            wr(FLAG_OFFSET, 8'h03);
            wr(EDGE_OFFSET, e[0] ? 8'h03 : 8'h00);
            wr(ENABLE_OFFSET, 8'h01 << ch);
            // wrong edge first
            field_level <= ~field_level;
            cyc(6 + $urandom_range(3));
            rdchk(FLAG_OFFSET, 8'h00, "wrong edge");
            check({7'h00, irq_request}, 8'h00, "irq idle");
            field_level <= ~field_level;
            cyc(6);
            rdchk(FLAG_OFFSET, 8'h01 << ch, "edge flag");
            check({7'h00, irq_request}, 8'h01, "irq up");
            // zero bits are ignored
            wr(FLAG_OFFSET, 8'($urandom & ~(32'h1 << ch)));
            rdchk(FLAG_OFFSET, 8'h01 << ch, "write 0");
            // more edges while pending do not clear it
            field_level <= ~field_level;
            cyc(6);
            field_level <= ~field_level;
            cyc(6);
            rdchk(FLAG_OFFSET, 8'h01 << ch, "pending");
            wr(FLAG_OFFSET, 8'h01 << ch);
            cyc(2);
            rdchk(FLAG_OFFSET, 8'h00, "cleared");
            check({7'h00, irq_request}, 8'h00, "irq down");
            // a fresh edge after clearing is seen again
            field_level <= ~field_level;
            cyc(6);
            field_level <= ~field_level;
            cyc(6);
            rdchk(FLAG_OFFSET, 8'h01 << ch, "next");
            // disabling removes it from the line
            wr(ENABLE_OFFSET, 8'h00);
            cyc(2);
            check({7'h00, irq_request}, 8'h00, "disabled");
         end
      end
      $display("test edges done");
      // overrun status, clear and mask onto the line
      rdchk(OVR_STATUS_OFFSET, 8'h03, "ovr pending");
      wr(OVR_CLEAR_OFFSET, 8'h01);
      rdchk(OVR_STATUS_OFFSET, 8'h02, "ovr clear a");
      wr(OVR_CLEAR_OFFSET, 8'hFE);
      rdchk(OVR_STATUS_OFFSET, 8'h00, "ovr clear b");
      rdchk(OVR_CLEAR_OFFSET, 8'h00, "ovr clear reads 0");
      wr(FLAG_OFFSET, 8'h03);
      wr(OVR_ENABLE_OFFSET, 8'h03);
      rdchk(OVR_ENABLE_OFFSET, 8'h03, "ovr mask rb");
      wr(ENABLE_OFFSET, 8'h03);
      // fall, rise sets both, fall, rise lands on pending flags
      repeat (4) begin
         field_level <= ~field_level;
         cyc(6);
      end
      rdchk(OVR_STATUS_OFFSET, 8'h03, "ovr both");
      wr(FLAG_OFFSET, 8'h03);
      wr(ENABLE_OFFSET, 8'h00);
      cyc(2);
      check({7'h00, irq_request}, 8'h01, "ovr on line");
      wr(OVR_CLEAR_OFFSET, 8'h03);
      cyc(2);
      check({7'h00, irq_request}, 8'h00, "ovr off line");
      wr(OVR_ENABLE_OFFSET, 8'h00);
      $display("test overrun done");
      // counter request shares the line
      wr(FLAG_OFFSET, 8'h03);
      @(posedge clk_sys);
      counter_irq_req <= 1'b1;
      cyc(3);
      check({7'h00, irq_request}, 8'h01, "counter share");
      counter_irq_req <= 1'b0;
      cyc(3);
      check({7'h00, irq_request}, 8'h00, "counter off");
      $display("test shared line done");
      print_verdict();
   end
endmodule
